// ===== design/wdg_pkg.sv
// Function
// R1: Boot watchdog is disabled or times out after 30 s, 1, 2, 5, 10, 30 min.
// R2: Boot watchdog counts only in self-test and resets the system on expiry.
// R3: Optionally the boot watchdog pauses during boot popup or password entry.
// R4: Runtime watchdog arms at boot: off, one-time, single or repeated.
// R5: One-time mode turns the runtime watchdog off at the first trigger.
// R6: Single event mode runs each configured stage once, then disables itself.
// R7: Repeated event mode reruns the last stage until a system reset.
// R8: Runtime watchdog waits a start delay chosen from the boot timeout set.
// R9: Stage one raises NMI, ACPI, reset or power button; cannot be off.
// R10: Second and third stages raise their own event, or may be disabled.
// R11: Stage timeouts are 0.5, 1, 2, 5, 10, 30 s, 1 or 2 min.
// R12: The ACPI event requests either an orderly shutdown or a restart.
// R13: ACPI shutdown signals an over-temperature notification to the OS.
// R14: ACPI restart reports a fatal error to the OS.
// R15: Each trigger reloads the first stage timeout and returns to it.
// R16: After a stage event the next enabled stage starts; order is 1, 2, 3.
package wdg_pkg;
   localparam int unsigned WDG_CLK_PERIOD_NS = 10;
   localparam int unsigned WDG_TICK_MS = 500;
   localparam int unsigned WDG_TICK_CYC =
      WDG_TICK_MS * 1000000 / WDG_CLK_PERIOD_NS;
   localparam int WDG_TW = 12;
   localparam int WDG_AW = 8;
   localparam logic [7:0] WDG_CFG_OFS = 8'h00;
   localparam logic [7:0] WDG_TMO_OFS = 8'h04;
   localparam logic [7:0] WDG_EVT_OFS = 8'h08;
   localparam logic [7:0] WDG_KICK_OFS = 8'h0C;
   localparam logic [7:0] WDG_STAT_OFS = 8'h10;
   localparam logic [7:0] WDG_ISR_OFS = 8'h14;
   localparam logic [7:0] WDG_IMR_OFS = 8'h18;
   localparam logic [8:0] WDG_CFG_RST = 9'h000;
   localparam logic [8:0] WDG_TMO_RST = 9'h000;
   localparam logic [8:0] WDG_EVT_RST = 9'h000;
   localparam logic [2:0] WDG_ISR_RST = 3'h0;
   localparam logic [2:0] WDG_IMR_RST = 3'h0;
   localparam int WDG_ISR_STAGE = 0;
   localparam int WDG_ISR_BOOT = 1;
   localparam int WDG_ISR_OFF = 2;

   typedef enum logic [1:0] {
      WDG_M_OFF = 2'h0,
      WDG_M_ONCE = 2'h1,
      WDG_M_SINGLE = 2'h2,
      WDG_M_REPEAT = 2'h3
   } wdg_mode_t;

   typedef enum logic [1:0] {
      WDG_EV_NMI = 2'h0,
      WDG_EV_ACPI = 2'h1,
      WDG_EV_RESET = 2'h2,
      WDG_EV_PWR = 2'h3
   } wdg_ev_t;

   typedef enum logic [2:0] {
      WDG_RT_OFF = 3'b001,
      WDG_RT_DELAY = 3'b010,
      WDG_RT_STAGE = 3'b100
   } wdg_rt_t;

   function automatic logic [WDG_TW-1:0] wdg_ms2tick(input int unsigned ms);
      return WDG_TW'(ms / WDG_TICK_MS);
   endfunction

   // Boot and delay selector; zero means disabled.
   function automatic logic [WDG_TW-1:0] wdg_boot_ticks(input logic [2:0] s);
      logic [WDG_TW-1:0] t;
      t = '0;
      unique case (s) // [R1] [R8]
         3'h1: t = wdg_ms2tick(30000);
         3'h2: t = wdg_ms2tick(60000);
         3'h3: t = wdg_ms2tick(120000);
         3'h4: t = wdg_ms2tick(300000);
         3'h5: t = wdg_ms2tick(600000);
         3'h6: t = wdg_ms2tick(1800000);
         default: t = '0;
      endcase
      return t;
   endfunction

   function automatic logic [WDG_TW-1:0] wdg_stage_ticks(input logic [2:0] s);
      logic [WDG_TW-1:0] t;
      t = '0;
      unique case (s) // [R11]
         3'h0: t = wdg_ms2tick(500);
         3'h1: t = wdg_ms2tick(1000);
         3'h2: t = wdg_ms2tick(2000);
         3'h3: t = wdg_ms2tick(5000);
         3'h4: t = wdg_ms2tick(10000);
         3'h5: t = wdg_ms2tick(30000);
         3'h6: t = wdg_ms2tick(60000);
         3'h7: t = wdg_ms2tick(120000);
      endcase
      return t;
   endfunction
endpackage

// ===== design/wdg_evt_if.sv
`timescale 1ns/1ps
interface wdg_evt_if;
   import wdg_pkg::*;
   logic valid;
   wdg_ev_t kind;
   logic restart;
   modport src (output valid, output kind, output restart);
   modport dst (input valid, input kind, input restart);
endinterface

// ===== design/wdg_timer.sv
`timescale 1ns/1ps
module wdg_timer
   import wdg_pkg::*;
#(
   parameter int unsigned TICK_CYC = WDG_TICK_CYC
)
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic load_i,
   input wire logic [WDG_TW-1:0] ticks_i,
   input wire logic run_i,
   output logic expire_o
);
   logic [31:0] pre;
   logic [WDG_TW-1:0] cnt;
   logic tick;

   // The prescaler restarts on every load so a timeout is never short.
   // The expiry ignores the load, so a caller may reload on it without a
   // combinational loop; a caller that must not expire then drops run_i.
   assign tick = run_i && (cnt != '0) && (pre == 32'(TICK_CYC - 1));
   assign expire_o = tick && (cnt == WDG_TW'(1));

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pre <= '0;
         cnt <= '0;
      end
      else if (load_i)
      begin
         pre <= '0;
         cnt <= ticks_i;
      end
      else if (tick)
      begin
         pre <= '0;
         cnt <= cnt - WDG_TW'(1);
      end
      else if (run_i && cnt != '0)
         pre <= pre + 32'h0000_0001;
   end
endmodule

// ===== design/wdg_evt_gen.sv
`timescale 1ns/1ps
module wdg_evt_gen
   import wdg_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   wdg_evt_if.dst ev,
   output logic nmi_o,
   output logic ovt_notify_o,
   output logic fatal_err_o,
   output logic sys_reset_o,
   output logic pwr_btn_o
);
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         nmi_o <= 1'b0;
         ovt_notify_o <= 1'b0;
         fatal_err_o <= 1'b0;
         sys_reset_o <= 1'b0;
         pwr_btn_o <= 1'b0;
      end
      else
      begin
         nmi_o <= ev.valid && ev.kind == WDG_EV_NMI; // [R9] [R10]
         ovt_notify_o <= ev.valid && ev.kind == WDG_EV_ACPI
            && !ev.restart; // [R12] [R13]
         fatal_err_o <= ev.valid && ev.kind == WDG_EV_ACPI
            && ev.restart; // [R12] [R14]
         sys_reset_o <= ev.valid && ev.kind == WDG_EV_RESET;
         pwr_btn_o <= ev.valid && ev.kind == WDG_EV_PWR;
      end
   end
endmodule

// ===== design/wdg_top.sv
`timescale 1ns/1ps
module wdg_top
   import wdg_pkg::*;
#(
   parameter int unsigned TICK_CYC = WDG_TICK_CYC
)
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [WDG_AW-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic post_i,
   input wire logic user_wait_i,
   output logic nmi_o,
   output logic ovt_notify_o,
   output logic fatal_err_o,
   output logic sys_reset_o,
   output logic pwr_btn_o,
   output logic irq_o
);
   logic [8:0] cfg;
   logic [8:0] tmo;
   logic [8:0] evc;
   logic [2:0] isr;
   logic [2:0] imr;
   logic [31:0] next_rdata;
   logic post_q;
   logic post_fall;
   logic post_rise;
   logic boot_run;
   logic boot_exp;
   logic rt_exp;
   logic rt_load;
   logic [WDG_TW-1:0] rt_ld;
   logic kick;
   logic self_off;
   logic stage_fire;
   wdg_rt_t rt_state;
   wdg_rt_t next_state;
   logic [1:0] stage;
   logic [1:0] next_stage;
   wdg_mode_t mode;
   logic [WDG_TW-1:0] boot_ld;
   logic [WDG_TW-1:0] delay_ld;
   wdg_evt_if evi ();

   assign mode = wdg_mode_t'(cfg[5:4]);
   assign boot_ld = wdg_boot_ticks(cfg[2:0]);
   assign delay_ld = wdg_boot_ticks(cfg[8:6]);
   assign kick = wr_i && addr_i == WDG_KICK_OFS && wdata_i[0];
   assign post_rise = post_i && !post_q;
   assign post_fall = !post_i && post_q;

   function automatic logic [2:0] tsel(input logic [1:0] s,
      input logic [8:0] t);
      return (s == 2'h3) ? t[8:6] : (s == 2'h2) ? t[5:3] : t[2:0];
   endfunction

   function automatic wdg_ev_t evsel(input logic [1:0] s, input logic [8:0] e);
      return wdg_ev_t'((s == 2'h3) ? e[7:6] : (s == 2'h2) ? e[4:3] : e[1:0]);
   endfunction

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         cfg <= WDG_CFG_RST;
         tmo <= WDG_TMO_RST;
         evc <= WDG_EVT_RST;
         imr <= WDG_IMR_RST;
      end
      else if (wr_i)
      begin
         if (addr_i == WDG_CFG_OFS)
            cfg <= wdata_i[8:0];
         if (addr_i == WDG_TMO_OFS)
            tmo <= wdata_i[8:0];
         if (addr_i == WDG_EVT_OFS)
            evc <= wdata_i[8:0];
         if (addr_i == WDG_IMR_OFS)
            imr <= wdata_i[2:0];
      end
   end

   // A new event in the same cycle as its clear is kept.
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         isr <= WDG_ISR_RST;
      else
      begin
         isr <= (isr & ~((wr_i && addr_i == WDG_ISR_OFS) ? wdata_i[2:0]
            : 3'h0)) | {self_off, boot_exp, stage_fire};
      end
   end

   assign irq_o = |(isr & imr);

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (rd_i)
      begin
         unique case (addr_i)
            WDG_CFG_OFS: next_rdata = {23'h000000, cfg};
            WDG_TMO_OFS: next_rdata = {23'h000000, tmo};
            WDG_EVT_OFS: next_rdata = {23'h000000, evc};
            WDG_STAT_OFS: next_rdata = {26'h0000000, boot_run, stage, rt_state};
            WDG_ISR_OFS: next_rdata = {29'h00000000, isr};
            WDG_IMR_OFS: next_rdata = {29'h00000000, imr};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rdata_o <= 32'h0000_0000;
         post_q <= 1'b0;
      end
      else
      begin
         rdata_o <= next_rdata;
         post_q <= post_i;
      end
   end

   // Pausing also freezes the prescaler, so waiting time is not charged.
   assign boot_run = post_i && boot_ld != '0
      && !(cfg[3] && user_wait_i); // [R2] [R3]

   // A count left over from a stopped self-test must not expire on reload.
   wdg_timer #(.TICK_CYC(TICK_CYC)) u_boot (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .load_i(post_rise),
      .ticks_i(boot_ld),
      .run_i(boot_run && !post_rise),
      .expire_o(boot_exp)
   );

   wdg_timer #(.TICK_CYC(TICK_CYC)) u_rt (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .load_i(rt_load),
      .ticks_i(rt_ld),
      .run_i(rt_state != WDG_RT_OFF),
      .expire_o(rt_exp)
   );

   // A trigger in the cycle of an expiry wins; software was in time.
   assign stage_fire = rt_state == WDG_RT_STAGE && rt_exp && !kick;

   always_comb
   begin
      next_state = rt_state;
      next_stage = stage;
      rt_load = 1'b0;
      rt_ld = wdg_stage_ticks(tmo[2:0]);
      self_off = 1'b0;
      unique case (rt_state)
         WDG_RT_OFF:
         begin
            if (post_fall && mode != WDG_M_OFF) // [R4]
            begin
               rt_load = 1'b1;
               if (delay_ld == '0)
               begin
                  next_state = WDG_RT_STAGE;
                  next_stage = 2'h1;
               end
               else
               begin
                  next_state = WDG_RT_DELAY; // [R8]
                  rt_ld = delay_ld;
               end
            end
         end
         WDG_RT_DELAY:
         begin
            if (mode == WDG_M_OFF)
               next_state = WDG_RT_OFF;
            else if (rt_exp)
            begin
               next_state = WDG_RT_STAGE;
               next_stage = 2'h1;
               rt_load = 1'b1;
            end
         end
         WDG_RT_STAGE:
         begin
            if (mode == WDG_M_OFF)
               next_state = WDG_RT_OFF;
            else if (kick && mode == WDG_M_ONCE)
            begin
               next_state = WDG_RT_OFF; // [R5]
               self_off = 1'b1;
            end
            else if (kick)
            begin
               next_stage = 2'h1; // [R15]
               rt_load = 1'b1;
            end
            else if (rt_exp)
            begin
               if (stage == 2'h1 && evc[2])
               begin
                  next_stage = 2'h2; // [R16]
                  rt_ld = wdg_stage_ticks(tmo[5:3]);
                  rt_load = 1'b1;
               end
               else if (stage != 2'h3 && evc[5])
               begin
                  next_stage = 2'h3; // [R16]
                  rt_ld = wdg_stage_ticks(tmo[8:6]);
                  rt_load = 1'b1;
               end
               else if (mode == WDG_M_REPEAT)
               begin
                  rt_ld = wdg_stage_ticks(tsel(stage, tmo)); // [R7]
                  rt_load = 1'b1;
               end
               else
               begin
                  next_state = WDG_RT_OFF; // [R6]
                  self_off = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rt_state <= WDG_RT_OFF;
         stage <= 2'h0;
      end
      else
      begin
         rt_state <= next_state;
         stage <= (next_state == WDG_RT_OFF) ? 2'h0 : next_stage;
      end
   end

   // A boot expiry resets the system and outranks any stage event.
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         evi.valid <= 1'b0;
         evi.kind <= WDG_EV_NMI;
         evi.restart <= 1'b0;
      end
      else
      begin
         evi.valid <= boot_exp || stage_fire; // [R9] [R10]
         evi.kind <= boot_exp ? WDG_EV_RESET : evsel(stage, evc); // [R2]
         evi.restart <= evc[8]; // [R12]
      end
   end

   wdg_evt_gen u_evt (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .ev(evi.dst),
      .nmi_o(nmi_o),
      .ovt_notify_o(ovt_notify_o),
      .fatal_err_o(fatal_err_o),
      .sys_reset_o(sys_reset_o),
      .pwr_btn_o(pwr_btn_o)
   );

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   a_boot_in_post: assert property (boot_exp |-> post_i) // [R2]
      else $error("boot watchdog expired outside self-test");
   a_boot_pause_hold: assert property (!boot_run && !post_rise // [R3]
      |=> $stable(u_boot.pre) && $stable(u_boot.cnt))
      else $error("boot timer moved while stopped");
   a_boot_reset_out: assert property (boot_exp |-> ##2 sys_reset_o) // [R2]
      else $error("boot expiry gave no system reset");
   a_rt_arm: assert property (rt_state == WDG_RT_OFF && post_fall // [R4]
      && mode != WDG_M_OFF |=> rt_state != WDG_RT_OFF)
      else $error("runtime watchdog not armed");
   a_once_off: assert property (rt_state == WDG_RT_STAGE && kick // [R5]
      && mode == WDG_M_ONCE |=> rt_state == WDG_RT_OFF)
      else $error("one-time mode stayed on after trigger");
   a_kick_reload: assert property (rt_state == WDG_RT_STAGE && kick // [R15]
      && mode inside {WDG_M_SINGLE, WDG_M_REPEAT} |=> stage == 2'h1)
      else $error("trigger did not return to stage one");
   a_single_stop: assert property (stage_fire && mode == WDG_M_SINGLE // [R6]
      && stage == 2'h3 |=> rt_state == WDG_RT_OFF && isr[WDG_ISR_OFF])
      else $error("single mode did not stop after last stage");
   a_repeat_stay: assert property (stage_fire && mode == WDG_M_REPEAT // [R7]
      && stage == 2'h3 |=> rt_state == WDG_RT_STAGE
      && stage == $past(stage))
      else $error("repeat mode left the last stage");
   a_stage_next: assert property (stage_fire && mode != WDG_M_OFF // [R16]
      && stage == 2'h1 && evc[2] |=> stage == 2'h2)
      else $error("stage two not entered after stage one");
   a_stage_event: assert property (stage_fire && !boot_exp // [R9] [R10]
      |=> evi.valid && evi.kind == $past(evsel(stage, evc)))
      else $error("stage expiry raised the wrong event");
   a_acpi_kind: assert property (evi.valid && evi.kind == WDG_EV_ACPI // [R12]
      |=> (ovt_notify_o != fatal_err_o))
      else $error("ACPI event not mapped to one notification");

   c_boot_reset: cover property (boot_exp);
   c_kick: cover property (rt_state == WDG_RT_STAGE && kick);
   c_stage3: cover property (stage_fire && stage == 2'h3);
   c_once: cover property (self_off && mode == WDG_M_ONCE);
endmodule

// ===== testbench/wdg_host.sv
`timescale 1ns/1ps
module wdg_host
   import wdg_pkg::*;
(
   input wire logic clk_i,
   output logic [WDG_AW-1:0] addr_o,
   output logic [31:0] wdata_o,
   output logic wr_o,
   output logic rd_o,
   output logic post_o,
   output logic user_wait_o
);
   initial
   begin
      addr_o = 8'h00;
      wdata_o = 32'h0;
      wr_o = 1'b0;
      rd_o = 1'b0;
      post_o = 1'b0;
      user_wait_o = 1'b0;
   end

   // Idle address and data are inverted so stale values never look valid.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
   endtask

   // Software must kick before the running stage expires.
   task automatic kick();
      wr(WDG_KICK_OFS, $urandom() | 32'h1);
   endtask

   task automatic set_post(input logic v);
      @(posedge clk_i);
      post_o <= v;
   endtask

   task automatic hold_user(input int dly, input int len);
      repeat (dly) @(posedge clk_i);
      user_wait_o <= 1'b1;
      repeat (len) @(posedge clk_i);
      user_wait_o <= 1'b0;
   endtask
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import wdg_pkg::*;
   ;
   localparam int TK = 10;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [WDG_AW-1:0] addr;
   logic [31:0] wdata, rdata, v;
   logic wr, rd, post, uw, nmi, ovt, fat, rst, pwr, irq;
   logic rd_d = 1'b0;
   logic [31:0] exp_q[$];
   int num_errors = 0;
   int check_count = 0;
   int n;
   int btk[6] = '{60, 120, 240, 600, 1200, 3600};
   int stk[8] = '{1, 2, 4, 10, 20, 60, 120, 240};
   wire logic [4:0] evv = {pwr, rst, fat, ovt, nmi};

   always #5 clk = ~clk;

   wdg_top #(.TICK_CYC(TK)) i_dut (.clk_i(clk), .resetn_i(resetn),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .post_i(post), .user_wait_i(uw), .nmi_o(nmi),
      .ovt_notify_o(ovt), .fatal_err_o(fat), .sys_reset_o(rst),
      .pwr_btn_o(pwr), .irq_o(irq));

   wdg_host i_host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr), .rd_o(rd), .post_o(post), .user_wait_o(uw));

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e)
      begin
         num_errors++;
         $display("[FAIL] %0t ns seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // An event with nothing expected is compared against an impossible value.
   function automatic logic [31:0] pop();
      if (exp_q.size() == 0)
         return 32'hFFFFFFFF;
      return exp_q.pop_front();
   endfunction

   // Outputs are unknown until the first edge in reset, so reset gates both.
   always @(posedge clk)
   begin
      if (resetn && rd_d)
         chk(rdata, pop());
      if (resetn && evv !== 5'h00)
         chk({27'h0, evv}, pop());
      rd_d <= rd;
   end

   task automatic rdx(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      i_host.rd(a);
   endtask

   task automatic wait_ev(input logic [4:0] e, input int lim, output int c);
      exp_q.push_back({27'h0, e});
      c = 0;
      while (exp_q.size() != 0 && c < lim)
      begin
         @(posedge clk);
         c++;
      end
      if (exp_q.size() != 0)
      begin
         chk(32'h0, 32'h1);
         exp_q.delete();
      end
   endtask

   task automatic near(input int c, input int t);
      chk(32'((c >= t - 8) && (c <= t + 8)), 32'h1);
   endtask

   task automatic arm(input logic [8:0] cfg, input logic [8:0] tmo,
      input logic [8:0] evt);
      i_host.wr(WDG_TMO_OFS, {23'h0, tmo});
      i_host.wr(WDG_EVT_OFS, {23'h0, evt});
      i_host.wr(WDG_CFG_OFS, {23'h0, cfg});
      i_host.set_post(1'b1);
      i_host.set_post(1'b0);
   endtask

   initial
   begin
      #1000000;
      num_errors++;
      test_done();
   end

   initial
   begin
      void'($urandom(32'h5be3));
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      for (int i = 0; i < 8; i++)
         rdx(8'(i * 4), (i == 4) ? 32'h1 : 32'h0);
      for (int i = 0; i < 3; i++)
      begin
         v = $urandom();
         i_host.wr(8'(i * 4), v);
         rdx(8'(i * 4), v & 32'h1FF);
      end
      $display("register test done");
      for (int s = 1; s <= 6; s++)
      begin
         i_host.wr(WDG_CFG_OFS, 32'(s) | 32'h8);
         i_host.set_post(1'b1);
         fork
            wait_ev(5'h08, btk[s - 1] * TK + 200, n);
            i_host.hold_user(20, 40);
         join
         near(n, btk[s - 1] * TK + 40);
         i_host.set_post(1'b0);
      end
      rdx(WDG_ISR_OFS, 32'h2);
      i_host.wr(WDG_IMR_OFS, 32'h1);
      @(negedge clk) chk({31'h0, irq}, 32'h0);
      i_host.wr(WDG_IMR_OFS, 32'h2);
      @(negedge clk) chk({31'h0, irq}, 32'h1);
      i_host.wr(WDG_ISR_OFS, 32'h2);
      @(negedge clk) chk({31'h0, irq}, 32'h0);
      $display("boot watchdog test done");
      for (int s = 0; s < 8; s++)
      begin
         arm(9'h030, 9'(s), 9'h000);
         wait_ev(5'h01, stk[s] * TK + 100, n);
         wait_ev(5'h01, stk[s] * TK + 100, n);
         near(n, stk[s] * TK);
         i_host.wr(WDG_CFG_OFS, 32'h0);
      end
      $display("stage timeout test done");
      i_host.wr(WDG_ISR_OFS, 32'h7);
      arm(9'h020, 9'h008, 9'h0AC);
      wait_ev(5'h01, 100, n);
      wait_ev(5'h02, 100, n);
      near(n, 2 * TK);
      wait_ev(5'h08, 100, n);
      repeat (50) @(posedge clk);
      rdx(WDG_STAT_OFS, 32'h1);
      rdx(WDG_ISR_OFS, 32'h5);
      $display("single event test done");
      arm(9'h030, 9'h000, 9'h163);
      wait_ev(5'h10, 100, n);
      wait_ev(5'h04, 100, n);
      wait_ev(5'h04, 100, n);
      repeat (8) i_host.kick();
      wait_ev(5'h10, 100, n);
      near(n, TK);
      i_host.wr(WDG_CFG_OFS, 32'h0);
      $display("repeated event test done");
      i_host.wr(WDG_ISR_OFS, 32'h7);
      arm(9'h060, 9'h000, 9'h000);
      rdx(WDG_STAT_OFS, 32'h2);
      wait_ev(5'h01, 900, n);
      near(n, btk[0] * TK + TK);
      repeat (20) @(posedge clk);
      i_host.wr(WDG_ISR_OFS, 32'h7);
      arm(9'h010, 9'h002, 9'h000);
      i_host.kick();
      rdx(WDG_STAT_OFS, 32'h1);
      repeat (100) @(posedge clk);
      rdx(WDG_ISR_OFS, 32'h4);
      repeat (4) @(posedge clk);
      $display("delay and one-time test done");
      test_done();
   end
endmodule
